/* File: common/shadow_pkg.sv */
// constants for the per-port shadowed control register at 38h
package shadow_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int PAY_W = 10;
    localparam int SEL_W = 5;
    localparam int NPORTS_DEF = 8;
    localparam logic [7:0] SHADOW_OFS = 8'h38;
    localparam logic [4:0] PAGE_HI = 5'h02;
    localparam int WE_BIT = 15;
    localparam int SEL_LSB = 10;

    // ------------------------------------------------------------
    // shadow codes
    // ------------------------------------------------------------
    localparam logic [4:0] SH_SPARE2 = 5'h04;
    localparam logic [4:0] SH_APD = 5'h0a;
    localparam logic [4:0] SH_LED2 = 5'h0e;
    localparam logic [4:0] SEL_RESET = 5'h00;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam logic [9:0] SPARE_RW_MASK = 10'h2e3;
    localparam logic [9:0] SPARE_RESET = 10'h000;
    localparam int RETRY_LSB = 2;
    localparam logic [2:0] RETRY_RESET = 3'h3;
    localparam logic [3:0] RETRY_BASE = 4'h2;
    localparam int ED_ROUTE_BIT = 1;
    localparam logic [9:0] APD_RESET = 10'h001;
    localparam int APD_EN_BIT = 5;
    localparam int APD_SLEEP_BIT = 4;
    localparam logic [9:0] LED_RESET = 10'h063;
    localparam logic [3:0] LED_IRQ_OUT_N = 4'h6;
    localparam logic [3:0] LED_OFF = 4'he;
    localparam logic [3:0] LED_ON = 4'hf;

    // ------------------------------------------------------------
    // timing (250 MHz clock)
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TICK_US = 100;
    localparam int TICK_CYCLES = TICK_US * 1000000 / CLK_PERIOD_PS;
    localparam int SLEEP_SHORT_MS = 2700;
    localparam int SLEEP_LONG_MS = 5400;
    localparam int WAKE_UNIT_MS = 84;
    localparam int WAKE_AWAKE_US = 1000;
    localparam logic [15:0] SLEEP_SHORT_TICKS = 16'(SLEEP_SHORT_MS * 1000 / TICK_US);
    localparam logic [15:0] SLEEP_LONG_TICKS = 16'(SLEEP_LONG_MS * 1000 / TICK_US);
    localparam logic [15:0] WAKE_UNIT_TICKS = 16'(WAKE_UNIT_MS * 1000 / TICK_US);
    localparam logic [15:0] WAKE_AWAKE_TICKS = 16'(WAKE_AWAKE_US / TICK_US);
endpackage

/* File: hw/apd_timer.sv */
// auto power-down sleep and wake-up sequencer for one port
`timescale 1ns/1ps
module apd_timer (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // timebase and control
    input wire logic tick,
    input wire logic enable,
    input wire logic sleep_long,
    input wire logic [3:0] wake_code,
    input wire logic energy,
    // status
    output logic low_power
);
    import shadow_pkg::*;

    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b100
    } apd_state_e;

    apd_state_e state;
    logic [15:0] count;
    logic [15:0] sleep_limit;
    logic [15:0] wake_limit;

    // code 0 behaves as one unit so the wake interval never collapses
    assign sleep_limit = sleep_long ? SLEEP_LONG_TICKS : SLEEP_SHORT_TICKS;
    assign wake_limit = 16'((wake_code == 4'h0 ? 4'h1 : wake_code) * WAKE_UNIT_TICKS);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_ACTIVE;
            count <= 16'h0000;
            low_power <= 1'b0;
        end else if (!enable || energy) begin
            state <= ST_ACTIVE;
            count <= 16'h0000;
            low_power <= 1'b0;
        end else if (tick) begin
            unique case (state)
                ST_ACTIVE: begin
                    if (count >= sleep_limit - 16'h0001) begin
                        state <= ST_SLEEP;
                        count <= 16'h0000;
                        low_power <= 1'b1;
                    end else begin
                        count <= count + 16'h0001;
                    end
                end
                ST_SLEEP: begin
                    if (count >= wake_limit - 16'h0001) begin
                        state <= ST_WAKE;
                        count <= 16'h0000;
                        low_power <= 1'b0;
                    end else begin
                        count <= count + 16'h0001;
                    end
                end
                ST_WAKE: begin
                    if (count >= WAKE_AWAKE_TICKS - 16'h0001) begin
                        state <= ST_SLEEP;
                        count <= 16'h0000;
                        low_power <= 1'b1;
                    end else begin
                        count <= count + 16'h0001;
                    end
                end
            endcase
        end
    end
endmodule

/* File: hw/shadow_ctrl.sv */
// shadowed register 38h bank with led, interrupt-pin and power-down control per port
`timescale 1ns/1ps

module shadow_ctrl #(
    parameter int NPORTS = shadow_pkg::NPORTS_DEF,
    parameter int TICK_CYCLES = shadow_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [shadow_pkg::ADDR_W-1:0] addr,
    input wire logic [shadow_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [shadow_pkg::DATA_W-1:0] rdata,
    // per-port status inputs
    input wire logic [NPORTS-1:0] link_rate_ind1,
    input wire logic [NPORTS-1:0] link_rate_ind2,
    input wire logic [NPORTS-1:0] tx_led,
    input wire logic [NPORTS-1:0] activity,
    input wire logic [NPORTS-1:0] full_duplex_led,
    input wire logic [NPORTS-1:0] slave,
    input wire logic [NPORTS-1:0] quality,
    input wire logic [NPORTS-1:0] rx_led,
    input wire logic [NPORTS-1:0] speed_fallback_ind,
    input wire logic [NPORTS-1:0] multicolor1,
    input wire logic [NPORTS-1:0] multicolor2,
    input wire logic [NPORTS-1:0] cable_fault,
    input wire logic [NPORTS-1:0] carrier_sense,
    input wire logic [NPORTS-1:0] energy_detect,
    input wire logic [NPORTS-1:0] irq_src_n,
    // per-port outputs and the downgrade attempt count taken from port 0
    output logic [NPORTS-1:0] irq_out_n,
    output logic [NPORTS-1:0] third_led,
    output logic [NPORTS-1:0] fourth_led,
    output logic [NPORTS-1:0] low_power,
    output logic [3:0] downgrade_attempts
);
    import shadow_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [SEL_W-1:0] sel [NPORTS];
    logic [PAY_W-1:0] spare [NPORTS];
    logic [PAY_W-1:0] apd [NPORTS];
    logic [PAY_W-1:0] led [NPORTS];
    logic [15:0] tick_cnt;
    logic tick;
    logic wr_hit;
    logic rd_hit;
    logic [2:0] port;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return (a[7:0] == SHADOW_OFS) && (a[15:11] == PAGE_HI) && (32'(a[10:8]) < NPORTS);
    endfunction

    function automatic logic led_pick(input logic [3:0] code, input logic [15:0] src);
        return src[code];
    endfunction

    function automatic logic [PAY_W-1:0] spare_view(input logic [PAY_W-1:0] s);
        return (s & SPARE_RW_MASK) | (PAY_W'(RETRY_RESET) << RETRY_LSB);
    endfunction

    assign port = addr[10:8];
    assign wr_hit = wr && addr_hit(addr);
    assign rd_hit = rd && addr_hit(addr);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NPORTS; i++) begin
                sel[i] <= SEL_RESET;
                spare[i] <= SPARE_RESET;
                apd[i] <= APD_RESET;
                led[i] <= LED_RESET;
            end
        end else if (wr_hit) begin
            sel[port] <= wdata[WE_BIT-1:SEL_LSB];
            if (wdata[WE_BIT]) begin
                unique case (wdata[WE_BIT-1:SEL_LSB])
                    SH_SPARE2: spare[port] <= wdata[PAY_W-1:0] & SPARE_RW_MASK;
                    SH_APD: apd[port] <= wdata[PAY_W-1:0];
                    SH_LED2: led[port] <= wdata[PAY_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
        end else if (rd_hit) begin
            unique case (sel[port])
                SH_SPARE2: rdata <= {1'b0, sel[port], spare_view(spare[port])};
                SH_APD: rdata <= {1'b0, sel[port], apd[port]};
                SH_LED2: rdata <= {1'b0, sel[port], led[port]};
                default: rdata <= {1'b0, sel[port], 10'h000};
            endcase
        end else begin
            rdata <= '0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            downgrade_attempts <= RETRY_BASE + 4'(RETRY_RESET);
        end else begin
            downgrade_attempts <= RETRY_BASE + {1'b0, 3'(spare_view(spare[0]) >> RETRY_LSB)};
        end
    end

    // ------------------------------------------------------------
    // interrupt pin and led selection
    // ------------------------------------------------------------
    logic [NPORTS-1:0] irq_out_n_n;
    logic [15:0] src4 [NPORTS];
    logic [15:0] src3 [NPORTS];

    // source vectors indexed by selector code
    always_comb begin
        for (int i = 0; i < NPORTS; i++) begin
            irq_out_n_n[i] = spare[i][ED_ROUTE_BIT] ? !energy_detect[i] : irq_src_n[i];
            src4[i] = {1'b0, 1'b1, carrier_sense[i], 1'b1, cable_fault[i], multicolor2[i],
                       speed_fallback_ind[i], rx_led[i], quality[i], irq_out_n_n[i], slave[i],
                       full_duplex_led[i], activity[i], tx_led[i], link_rate_ind2[i],
                       link_rate_ind1[i]};
            src3[i] = {src4[i][15:11], multicolor1[i], src4[i][9:0]};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_out_n <= '1;
            third_led <= '1;
            fourth_led <= '1;
        end else begin
            for (int i = 0; i < NPORTS; i++) begin
                irq_out_n[i] <= irq_out_n_n[i];
                fourth_led[i] <= led_pick(led[i][7:4], src4[i]);
                third_led[i] <= led_pick(led[i][3:0], src3[i]);
            end
        end
    end

    // ------------------------------------------------------------
    // power-down timebase and per-port sequencers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (tick_cnt >= 16'(TICK_CYCLES - 1)) begin
            tick_cnt <= 16'h0000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
            tick <= 1'b0;
        end
    end

    for (genvar g = 0; g < NPORTS; g++) begin : g_apd
        apd_timer u_timer (
            .clk(clk),
            .resetn(resetn),
            .tick(tick),
            .enable(apd[g][APD_EN_BIT]),
            .sleep_long(apd[g][APD_SLEEP_BIT]),
            .wake_code(apd[g][3:0]),
            .energy(energy_detect[g]),
            .low_power(low_power[g])
        );
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_sel_write;
        wr_hit && port == 3'h0 |=> sel[0] == $past(wdata[14:10]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("selector not taken");

    property p_select_only;
        wr_hit && port == 3'h0 && !wdata[WE_BIT] |=> $stable(spare[0]) && $stable(apd[0]) && $stable(led[0]);
    endproperty
    a_select_only: assert property (p_select_only) else $error("payload changed without write enable");

    property p_spare_map;
        wr_hit && port == 3'h0 && wdata[WE_BIT] && wdata[14:10] == SH_SPARE2
            |=> spare[0][ED_ROUTE_BIT] == $past(wdata[ED_ROUTE_BIT]);
    endproperty
    a_spare_map: assert property (p_spare_map) else $error("spare shadow not written");

    property p_apd_map;
        wr_hit && port == 3'h0 && wdata[WE_BIT] && wdata[14:10] == SH_APD |=> apd[0] == $past(wdata[9:0]);
    endproperty
    a_apd_map: assert property (p_apd_map) else $error("power-down shadow not written");

    property p_led_map;
        wr_hit && port == 3'h0 && wdata[WE_BIT] && wdata[14:10] == SH_LED2 |=> led[0] == $past(wdata[9:0]);
    endproperty
    a_led_map: assert property (p_led_map) else $error("led shadow not written");

    property p_readback;
        rd_hit && port == 3'h0 && sel[0] == SH_APD |=> rdata == {1'b0, SH_APD, $past(apd[0])};
    endproperty
    a_readback: assert property (p_readback) else $error("wrong shadow read back");

    property p_idle_read;
        !rd_hit |=> rdata == 16'h0000;
    endproperty
    a_idle_read: assert property (p_idle_read) else $error("read data outside read slot");

    property p_retry;
        downgrade_attempts == RETRY_BASE + 4'(RETRY_RESET);
    endproperty
    a_retry: assert property (p_retry) else $error("wrong downgrade attempt count");

    property p_irq_route;
        spare[0][ED_ROUTE_BIT] |=> irq_out_n[0] == !$past(energy_detect[0]);
    endproperty
    a_irq_route: assert property (p_irq_route) else $error("energy detect not on interrupt pin");

    property p_led_force;
        led[0][3:0] == LED_OFF && led[0][7:4] == LED_ON |=> third_led[0] && !fourth_led[0];
    endproperty
    a_led_force: assert property (p_led_force) else $error("forced led level wrong");

    property p_port_isolation;
        wr_hit && port != 3'h0 |=> $stable(sel[0]) && $stable(apd[0]);
    endproperty
    a_port_isolation: assert property (p_port_isolation) else $error("other port changed port 0");

    property p_apd_off;
        !apd[0][APD_EN_BIT] ##1 !apd[0][APD_EN_BIT] |-> !low_power[0];
    endproperty
    a_apd_off: assert property (p_apd_off) else $error("low power while disabled");

    property p_spare_ro;
        wr_hit && port == 3'h0 && wdata[WE_BIT] && wdata[14:10] == SH_SPARE2
            |=> (spare[0] & ~SPARE_RW_MASK) == 10'h000;
    endproperty
    a_spare_ro: assert property (p_spare_ro) else $error("read-only spare bits written");

    property p_spare_read;
        rd_hit && port == 3'h0 && sel[0] == SH_SPARE2 |=> rdata[4:2] == RETRY_RESET;
    endproperty
    a_spare_read: assert property (p_spare_read) else $error("retry field read wrong");

    property p_led_irq_out_n;
        led[0][7:4] == LED_IRQ_OUT_N |=> fourth_led[0] == $past(irq_out_n_n[0]);
    endproperty
    a_led_irq_out_n: assert property (p_led_irq_out_n) else $error("fourth led not on interrupt source");

    property p_third_mc1;
        led[0][3:0] == 4'ha |=> third_led[0] == $past(multicolor1[0]);
    endproperty
    a_third_mc1: assert property (p_third_mc1) else $error("third led not on multicolor 1");

    property p_irq_normal;
        !spare[0][ED_ROUTE_BIT] |=> irq_out_n[0] == $past(irq_src_n[0]);
    endproperty
    a_irq_normal: assert property (p_irq_normal) else $error("normal interrupt not on pin");

    property p_read_port1;
        rd_hit && port == 3'h1 && sel[1] == SH_APD |=> rdata == {1'b0, SH_APD, $past(apd[1])};
    endproperty
    a_read_port1: assert property (p_read_port1) else $error("wrong shadow read on port 1");

    c_spare_read: cover property (rd_hit && sel[port] == SH_SPARE2);
    c_led_on: cover property (led[0][7:4] == LED_ON ##1 !fourth_led[0]);
    c_sleep: cover property (!low_power[0] ##1 low_power[0]);
    c_wake: cover property (low_power[0] ##1 !low_power[0]);
    c_irq_route: cover property (spare[0][ED_ROUTE_BIT] && !energy_detect[0]);
endmodule

/* File: verif/shadow_ctrl_test.sv */
// self-checking bench for the shadowed register bank and its pin outputs
`timescale 1ns/1ps
module shadow_ctrl_test;
    import shadow_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct {logic [15:0] a; logic [15:0] d; logic [15:0] m; logic [15:0] e;} row_s;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [15:0] pat = 16'h0000;
    logic [7:0] energy = 8'hff;
    logic [7:0] irq_out_n, third_led, fourth_led, low_power;
    logic [3:0] downgrade_attempts;
    int num_errors = 0;
    int comparisons = 0;
    int n;
    logic e;
    row_s rows [10] = '{
        '{16'h1038, 16'h2800, 16'hffff, 16'h2801},
        '{16'h1038, 16'h1000, 16'hfc1e, 16'h100c},
        '{16'h1038, 16'h3800, 16'hffff, 16'h3863},
        '{16'h1038, 16'ha83f, 16'hffff, 16'h283f},
        '{16'h1038, 16'h283e, 16'hffff, 16'h283f},
        '{16'h1038, 16'h93fd, 16'hfc1e, 16'h100c},
        '{16'h1038, 16'h8800, 16'hffff, 16'h0800},
        '{16'h1138, 16'h2800, 16'hffff, 16'h2801},
        '{16'h1039, 16'ha83f, 16'hffff, 16'h0000},
        '{16'h1838, 16'h2800, 16'hffff, 16'h0000}};

    always #2 clk = ~clk;

    shadow_ctrl #(.NPORTS(8), .TICK_CYCLES(2)) shadow_ctrl_inst (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .link_rate_ind1({8{pat[0]}}), .link_rate_ind2({8{pat[1]}}), .tx_led({8{pat[2]}}),
        .activity({8{pat[3]}}), .full_duplex_led({8{pat[4]}}), .slave({8{pat[5]}}),
        .irq_src_n({8{pat[6]}}), .quality({8{pat[7]}}), .rx_led({8{pat[8]}}),
        .speed_fallback_ind({8{pat[9]}}), .multicolor2({8{pat[10]}}), .cable_fault({8{pat[11]}}),
        .multicolor1({8{pat[12]}}), .carrier_sense({8{pat[13]}}), .energy_detect(energy),
        .irq_out_n(irq_out_n), .third_led(third_led), .fourth_led(fourth_led),
        .low_power(low_power), .downgrade_attempts(downgrade_attempts));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask

    // write, back-to-back read, data only in the one cycle after the read
    task automatic access(input row_s r);
        cyc(1'b1, 1'b0, r.a, r.d);
        cyc(1'b0, 1'b1, r.a, 16'h0000);
        cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
        #1 chk(rdata & r.m, r.e & r.m);
        cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
        #1 chk(rdata, 16'h0000);
    endtask

    task automatic settle();
        repeat (2) cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
        #1;
    endtask

    task automatic end_of_test();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // led level expected from the source table
    function automatic logic led_exp(input logic [3:0] c, input logic [15:0] p, input logic third);
        if (c == 4'hc || c == 4'he) return 1'b1;
        if (c == 4'hf) return 1'b0;
        if (third && c == 4'ha) return p[12];
        return p[c];
    endfunction

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #360000;
        num_errors++;
        end_of_test();
    end

    initial begin
        @(posedge clk);
        #1 chk({irq_out_n, third_led}, 16'hffff);
        chk({fourth_led, low_power}, 16'hff00);
        chk({12'h000, downgrade_attempts}, 16'h0005);
        @(posedge clk);
        resetn <= 1'b1;
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            access(rows[i]);
        end
        chk({12'h000, downgrade_attempts}, 16'h0005);
        $display("test register rows done");
        pat <= 16'h0040;
        settle();
        chk({15'h0, fourth_led[1]}, {15'h0, pat[6]});
        chk({15'h0, third_led[1]}, {15'h0, pat[3]});
        for (int c = 0; c < 16; c++) begin
            cyc(1'b1, 1'b0, 16'h1038, {8'hb8, c[3:0], c[3:0]});
            for (int k = 0; k < 2; k++) begin
                pat <= k ? 16'hd5a5 : 16'h2a5a;
                settle();
                chk({15'h0, fourth_led[0]}, {15'h0, led_exp(c[3:0], pat, 1'b0)});
                chk({15'h0, third_led[0]}, {15'h0, led_exp(c[3:0], pat, 1'b1)});
            end
        end
        cyc(1'b1, 1'b0, 16'h1038, 16'hb8fe);
        settle();
        chk({14'h0, fourth_led[0], third_led[0]}, 16'h0001);
        $display("test led sources done");
        pat <= 16'h0040;
        energy <= 8'hfe;
        cyc(1'b1, 1'b0, 16'h1038, 16'hb866);
        cyc(1'b1, 1'b0, 16'h1038, 16'h9002);
        settle();
        chk({8'h00, irq_out_n}, 16'h00ff);
        energy <= 8'hff;
        settle();
        chk({8'h00, irq_out_n}, 16'h00fe);
        chk({15'h0, fourth_led[0]}, 16'h0000);
        cyc(1'b1, 1'b0, 16'h1038, 16'h9000);
        settle();
        chk({8'h00, irq_out_n}, 16'h00ff);
        $display("test energy routing done");
        cyc(1'b1, 1'b0, 16'h1038, 16'ha821);
        settle();
        energy <= 8'hfe;
        n = 0;
        while (low_power[0] !== 1'b1 && n < 60000) begin
            @(posedge clk);
            #1;
            n++;
        end
        e = n >= 53996 && n <= 54004;
        chk({15'h0, e}, 16'h0001);
        chk({8'h00, low_power}, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while (low_power[0] === (k == 0) && n < 3000) begin
                @(posedge clk);
                #1;
                n++;
            end
            e = k ? (n >= 16 && n <= 24) : (n >= 1676 && n <= 1684);
            chk({15'h0, e}, 16'h0001);
        end
        energy <= 8'hff;
        settle();
        chk({8'h00, low_power}, 16'h0000);
        $display("test power-down timing done");
        @(posedge clk);
        resetn <= 1'b0;
        #1 chk({fourth_led, low_power}, 16'hff00);
        @(posedge clk);
        resetn <= 1'b1;
        access(rows[0]);
        access(rows[2]);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
